// file: rtl/sps_port.sv
// byte-wide serial port engine, master or slave, with pin control
module sps_port
#(
  parameter bit CLOCK_EDGE_OPTION = 1'b1,
  parameter bit COLLISION_OPT = 1'b1,
  parameter bit SELECT_OPT = 1'b1
)
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic BASE_CLOCK_SEL,
  input wire logic [1:0] MODE_SEL,
  input wire logic PORT_ENABLE,
  input wire logic MSB_FIRST_SEL,
  input wire logic SELECT_ENABLE,
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WDATA,
  output logic [7:0] SERIAL_DATA_REG,
  input wire logic WRITE_COLLISION_FLAG_CLR,
  input wire logic TRF_CLR,
  output logic WRITE_COLLISION_FLAG,
  output logic TRANSFER_DONE_FLAG,
  output logic SERIAL_PORT_IRQ,
  output logic BUSY,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic SELECT_LINE_N_I,
  output logic SELECT_LINE_N_O,
  output logic SELECT_LINE_N_OE,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT_O,
  output logic SERIAL_OUT_OE
);

  localparam logic ACT_LVL = CLOCK_EDGE_OPTION;
  localparam logic IDLE_LVL = ~CLOCK_EDGE_OPTION;

  sps_rate_if rif ();

  logic master;
  logic sel_en;
  logic mbusy;
  logic busy;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic sdo_q;
  logic sck_q;
  logic [7:0] data_reg;
  logic transfer_done_flag;
  logic write_collision_flag;
  logic irq;
  logic sck_s1, sck_s2, sck_s3;
  logic sel_s1, sel_s2;
  logic sdi_s1, sdi_s2;
  logic s_ok, s_act, s_trl, m_act, m_trl;
  logic act_ev, trl_ev, done;
  logic wr_ok, wr_col, m_start, s_start;

  // first bit to present, given the bit order
  function automatic logic out_bit(input logic [7:0] v, input logic msb);
    out_bit = msb ? v[7] : v[0];
  endfunction : out_bit

  // mode and select qualifiers
  assign master = (MODE_SEL != sps_pkg::SPS_SLAVE);
  assign sel_en = SELECT_OPT && SELECT_ENABLE;
  assign busy = master ? mbusy : (cnt != 4'h0);

  assign rif.base_sel = BASE_CLOCK_SEL;
  assign rif.mode = MODE_SEL;
  assign rif.run = master && mbusy && PORT_ENABLE;

  sps_rate u_rate
  (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .rif(rif)
  );

  // pin inputs pass two flops; a third flop only feeds edge detect
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end
    else
    begin
      sck_s1 <= SCK_I;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sel_s1 <= SELECT_LINE_N_I;
      sel_s2 <= sel_s1;
      sdi_s1 <= SERIAL_IN;
      sdi_s2 <= sdi_s1;
    end
  end

  // shift events; no halt input exists, so halting never stops them
  assign s_ok = !master && PORT_ENABLE && (!sel_en || !sel_s2);
  assign s_act = s_ok && (sck_s2 == ACT_LVL) && (sck_s3 != ACT_LVL);
  assign s_trl = s_ok && (sck_s2 != ACT_LVL) && (sck_s3 == ACT_LVL);
  assign m_act = rif.run && rif.tick && (sck_q == IDLE_LVL);
  assign m_trl = rif.run && rif.tick && (sck_q == ACT_LVL);
  assign act_ev = m_act || s_act;
  assign trl_ev = m_trl || s_trl;
  // master ends on the trailing edge so the clock lands at idle
  assign done = master ? (m_trl && cnt == sps_pkg::LAST_BIT)
                       : (s_act && cnt == sps_pkg::LAST_BIT - 4'h1);

  // writes load the shift buffer and in master mode start a transfer; busy writes collide
  assign wr_ok = DATA_WR && PORT_ENABLE && !busy;
  assign wr_col = DATA_WR && PORT_ENABLE && busy;
  assign m_start = wr_ok && master;
  assign s_start = s_act && (cnt == 4'h0);

  // bit order decides shift direction
  always_comb
  begin
    if (MSB_FIRST_SEL)
    begin
      next_sh = {sh[6:0], sdi_s2};
    end
    else
    begin
      next_sh = {sdi_s2, sh[7:1]};
    end
  end

  // shift buffer
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sh <= sps_pkg::DATA_RESET;
    end
    else if (wr_ok)
    begin
      sh <= DATA_WDATA;
    end
    else if (act_ev)
    begin
      sh <= next_sh;
    end
  end

  // bit counter and master busy
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cnt <= 4'h0;
      mbusy <= 1'b0;
    end
    else if (!PORT_ENABLE || done || (s_ok == 1'b0 && !master))
    begin
      // slave drops a partial byte when select goes away
      cnt <= 4'h0;
      mbusy <= 1'b0;
    end
    else if (m_start)
    begin
      cnt <= 4'h0;
      mbusy <= 1'b1;
    end
    else if (act_ev)
    begin
      cnt <= cnt + 4'h1;
    end
  end

  // serial out bit advances on trailing edges for hold margin; a write loads the first bit, done or disable parks it high
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sdo_q <= 1'b1;
    end
    else if (!PORT_ENABLE || done)
    begin
      sdo_q <= 1'b1;
    end
    else if (wr_ok)
    begin
      sdo_q <= out_bit(DATA_WDATA, MSB_FIRST_SEL);
    end
    else if (trl_ev)
    begin
      sdo_q <= out_bit(sh, MSB_FIRST_SEL);
    end
  end

  // master serial clock; parks at idle level
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sck_q <= IDLE_LVL;
    end
    else if (!rif.run)
    begin
      sck_q <= IDLE_LVL;
    end
    else if (rif.tick)
    begin
      sck_q <= ~sck_q;
    end
  end

  // received byte is latched on completion
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      data_reg <= sps_pkg::DATA_RESET;
    end
    else if (done)
    begin
      data_reg <= master ? sh : next_sh;
    end
  end

  // done flag: set wins over clear; start or disable clears it
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      transfer_done_flag <= 1'b0;
      irq <= 1'b0;
    end
    else if (!PORT_ENABLE)
    begin
      transfer_done_flag <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      irq <= done;
      if (done)
      begin
        transfer_done_flag <= 1'b1;
      end
      else if (TRF_CLR || m_start || s_start)
      begin
        transfer_done_flag <= 1'b0;
      end
    end
  end

  // collision flag: hardware sets, software clears, set wins
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      write_collision_flag <= 1'b0;
    end
    else if (!PORT_ENABLE)
    begin
      write_collision_flag <= 1'b0;
    end
    else if (wr_col && COLLISION_OPT)
    begin
      write_collision_flag <= 1'b1;
    end
    else if (WRITE_COLLISION_FLAG_CLR)
    begin
      write_collision_flag <= 1'b0;
    end
  end

  // pin drive per mode and enable state
  always_comb
  begin
    SCK_O = sck_q;
    SCK_OE = master && PORT_ENABLE;
    SERIAL_OUT_O = sdo_q;
    SERIAL_OUT_OE = master || PORT_ENABLE;
    SELECT_LINE_N_O = 1'b1;
    SELECT_LINE_N_OE = 1'b1;
    if (PORT_ENABLE)
    begin
      // master drives select low for the whole byte
      SELECT_LINE_N_O = !mbusy;
      SELECT_LINE_N_OE = master && sel_en;
    end
  end

  assign SERIAL_DATA_REG = data_reg;
  assign WRITE_COLLISION_FLAG = write_collision_flag;
  assign TRANSFER_DONE_FLAG = transfer_done_flag;
  assign SERIAL_PORT_IRQ = irq;
  assign BUSY = busy;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_master_write;
    master && PORT_ENABLE && DATA_WR && !busy;
  endsequence

  sequence s_busy_write;
    PORT_ENABLE && DATA_WR && busy;
  endsequence

  master_start_a: assert property (s_master_write |=> mbusy && !transfer_done_flag)
    else $error("master write did not start a transfer");
  collision_set_a: assert property (s_busy_write |=> write_collision_flag == COLLISION_OPT)
    else $error("busy write did not set collision flag");
  collision_drop_a: assert property (s_busy_write ##0 !act_ev |=> sh == $past(sh))
    else $error("busy write changed shift buffer");
  collision_cause_a: assert property ($rose(write_collision_flag) |-> $past(DATA_WR && busy))
    else $error("collision flag set without cause");
  done_pending_a: assert property (busy |-> !transfer_done_flag)
    else $error("done flag high during transfer");
  done_irq_a: assert property (done |=> transfer_done_flag && irq ##1 !irq)
    else $error("done flag or interrupt pulse wrong");
  disable_flags_a: assert property (!PORT_ENABLE |=> !transfer_done_flag && !write_collision_flag && !busy)
    else $error("disable did not clear flags");
  eight_bits_a: assert property (m_start && BASE_CLOCK_SEL && MODE_SEL == 2'h0
    |-> ##16 done) else $error("fast master byte not sixteen clock edges");
  master_idle_clk_a: assert property (master && PORT_ENABLE && !mbusy |-> SCK_OE
    && SCK_O == IDLE_LVL && SERIAL_OUT_O)
    else $error("master standby pins wrong");
  select_float_a: assert property (PORT_ENABLE && !sel_en |-> !SELECT_LINE_N_OE)
    else $error("select driven with select disabled");
  select_low_a: assert property (master && mbusy && sel_en && PORT_ENABLE
    |-> SELECT_LINE_N_OE && !SELECT_LINE_N_O)
    else $error("master select not low during transfer");
  master_off_a: assert property (master && !PORT_ENABLE |-> SELECT_LINE_N_O
    && SERIAL_OUT_O && SERIAL_OUT_OE && !SCK_OE)
    else $error("disabled master pins wrong");
  slave_gate_a: assert property (!master && sel_en && sel_s2 |=> cnt == 4'h0)
    else $error("slave shifted without select");

endmodule : sps_port

// file: rtl/sps_pkg.sv
// constants, types and rate table for the serial master/slave port
// Summary of operation
// - slave buffer shifts on master clock, latches result
// - write during transfer sets collision, is dropped
// - hardware sets collision, software clears; optional
// - shifting continues while processor halted
// - build option picks rising or falling edge
// - bit order control selects msb or lsb
// - select before clock; slave gated by select
// - select enable: master drives, slave gates
// - select enable off leaves select pin floating while port enabled
// - build option can force select enable off
// - standby pin levels per mode
// - disabled pin levels per mode
// - port disable resets all status flags
// - done flag set on finish, low while pending
// - mode field: three master rates or slave
// - clock select: half or full oscillator
// - master write starts transfer, clock and select
package sps_pkg;

  typedef enum logic [1:0]
  {
    SPS_MASTER_DIV1 = 2'b00,
    SPS_MASTER_DIV4 = 2'b01,
    SPS_MASTER_DIV16 = 2'b10,
    SPS_SLAVE = 2'b11
  } sps_mode_e;

  // bits per transfer
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h8;
  // baud divisors of the serial base clock
  localparam logic [5:0] DIV_1 = 6'h01;
  localparam logic [5:0] DIV_4 = 6'h04;
  localparam logic [5:0] DIV_16 = 6'h10;
  // reset values
  localparam logic [7:0] DATA_RESET = 8'h00;

endpackage : sps_pkg

// file: rtl/sps_rate_if.sv
// interface between the port engine and its bit rate generator
interface sps_rate_if;
  logic base_sel;
  logic [1:0] mode;
  logic run;
  logic tick;
  modport gen (input base_sel, input mode, input run, output tick);
  modport user (output base_sel, output mode, output run, input tick);
endinterface : sps_rate_if

// file: rtl/sps_rate.sv
// half bit period tick generator for master mode
module sps_rate
(
  input wire logic clk,
  input wire logic rst_n,
  sps_rate_if.gen rif
);

  logic [5:0] cnt;
  logic [5:0] half;

  // half period in clocks; full-rate gets clamped to one clock
  function automatic logic [5:0] half_count(input logic base_sel, input logic [1:0] mode);
    logic [5:0] div;
    logic [6:0] period;
    div = sps_pkg::DIV_1;
    if (mode == sps_pkg::SPS_MASTER_DIV4)
    begin
      div = sps_pkg::DIV_4;
    end
    else if (mode == sps_pkg::SPS_MASTER_DIV16)
    begin
      div = sps_pkg::DIV_16;
    end
    // base clock is oscillator or oscillator/2
    period = base_sel ? {1'b0, div} : {div, 1'b0};
    half_count = (period < 7'h02) ? 6'h01 : period[6:1];
  endfunction : half_count

  assign half = half_count(rif.base_sel, rif.mode);
  assign rif.tick = rif.run && (cnt == half - 6'h01);

  // free count only while a master transfer runs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 6'h00;
    end
    else if (!rif.run || rif.tick)
    begin
      cnt <= 6'h00;
    end
    else
    begin
      cnt <= cnt + 6'h01;
    end
  end

endmodule : sps_rate

// file: bench/sps_peer.sv
// behavioural spi peer: slave to a master port, master to a slave port
module sps_peer
(
  input wire logic dut_sck,
  input wire logic dut_sel_n,
  input wire logic dut_sdo,
  input wire logic msb,
  output logic sck,
  output logic sel_n,
  output logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic act = 1'b0;
  int n = 0;

  // clock idles low and stands still between frames
  initial
  begin
    sck = 1'b0;
    sel_n = 1'b1;
    serial_out = 1'b1;
  end

  function automatic logic pick(input logic [7:0] v, input int i);
    return msb ? v[7 - i] : v[i];
  endfunction : pick

  // slave role: first bit ready at select, next bits on trailing edges
  always @(negedge dut_sel_n)
  begin
    n = 0;
    if (!act)
      serial_out = pick(tx, 0);
  end
  always @(posedge dut_sck)
  begin
    if (!act && !dut_sel_n)
    begin
      rx = msb ? {rx[6:0], dut_sdo} : {dut_sdo, rx[7:1]};
      n = n + 1;
    end
  end
  always @(negedge dut_sck)
  begin
    if (!act && !dut_sel_n)
      serial_out = (n < 8) ? pick(tx, n) : ~serial_out; // released line must not keep its level
  end

  // master role: select leads the first edge by half a link period
  task automatic xfer(input logic [7:0] b, input logic use_sel);
    act = 1'b1;
    sel_n = ~use_sel;
    for (int i = 0; i < 8; i++)
    begin
      serial_out = pick(b, i);
      #62.5 sck = 1'b1;
      rx = msb ? {rx[6:0], dut_sdo} : {dut_sdo, rx[7:1]};
      #62.5 sck = 1'b0;
    end
    #62.5 sel_n = 1'b1;
    serial_out = ~serial_out;
    act = 1'b0;
  endtask : xfer
endmodule : sps_peer

// file: bench/tb_sps_port.sv
// self-checking bench for the serial master/slave port
module tb_sps_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, base_sel = 1'b0, port_en = 1'b0;
  logic [1:0] mode_sel = 2'b00;
  logic msb_sel = 1'b1, sel_en = 1'b1, data_wr = 1'b0, write_collision_flag_clr = 1'b0, trf_clr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic write_collision_flag, transfer_done_flag, irq, busy, sck_o, sck_oe, sel_n_o, sel_oe, sdo_o, sdo_oe;
  logic p_sck, p_sel_n, p_sdo;
  int errors = 0;
  int checked = 0;
  // resolved pin levels; an undriven select rests high
  wire logic sck = sck_oe ? sck_o : p_sck;
  wire logic sel_w = sel_oe ? sel_n_o : p_sel_n;

  sps_port sps_port_inst
  (
    .REF_CLK(clk), .RESETN(rst_n), .BASE_CLOCK_SEL(base_sel), .MODE_SEL(mode_sel),
    .PORT_ENABLE(port_en), .MSB_FIRST_SEL(msb_sel), .SELECT_ENABLE(sel_en),
    .DATA_WR(data_wr), .DATA_WDATA(wdata), .SERIAL_DATA_REG(rdata),
    .WRITE_COLLISION_FLAG_CLR(write_collision_flag_clr), .TRF_CLR(trf_clr), .WRITE_COLLISION_FLAG(write_collision_flag),
    .TRANSFER_DONE_FLAG(transfer_done_flag), .SERIAL_PORT_IRQ(irq), .BUSY(busy), .SCK_I(sck),
    .SCK_O(sck_o), .SCK_OE(sck_oe), .SELECT_LINE_N_I(sel_w), .SELECT_LINE_N_O(sel_n_o),
    .SELECT_LINE_N_OE(sel_oe), .SERIAL_IN(p_sdo), .SERIAL_OUT_O(sdo_o),
    .SERIAL_OUT_OE(sdo_oe)
  );
  sps_peer sps_peer_inst
  (
    .dut_sck(sck), .dut_sel_n(sel_w), .dut_sdo(sdo_o), .msb(msb_sel),
    .sck(p_sck), .sel_n(p_sel_n), .serial_out(p_sdo)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // sample just after the edge so its updates have landed
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    data_wr <= 1'b1;
    wdata <= d;
    @(posedge clk);
    data_wr <= 1'b0;
  endtask : wr

  task automatic clr;
    @(posedge clk);
    write_collision_flag_clr <= 1'b1;
    trf_clr <= 1'b1;
    @(posedge clk);
    write_collision_flag_clr <= 1'b0;
    trf_clr <= 1'b0;
    step();
  endtask : clr

  task automatic wait_done;
    int k = 0;
    while (transfer_done_flag !== 1'b1 && k < 3000)
    begin
      step();
      k++;
    end
    if (k == 3000)
    begin
      errors++;
      print_verdict();
    end
  endtask : wait_done

  task automatic cfg(input logic en, input logic [1:0] m, input logic se);
    @(posedge clk);
    port_en <= en;
    mode_sel <= m;
    sel_en <= se;
    repeat (4) step();
  endtask : cfg

  task automatic pins;
    chk(rdata, sps_pkg::DATA_RESET);
    cfg(1'b0, 2'b00, 1'b1);
    chk({sel_oe, sel_n_o, sdo_oe, sdo_o, sck_oe}, 5'b11110);
    cfg(1'b0, 2'b11, 1'b1);
    chk({sel_oe, sel_n_o, sdo_oe, sck_oe}, 4'b1100);
    cfg(1'b1, 2'b00, 1'b0);
    chk({sel_oe, sck_oe, sck_o, sdo_oe, sdo_o}, 5'b01011);
    cfg(1'b1, 2'b00, 1'b1);
    chk({sel_oe, sel_n_o}, 2'b11);
  endtask : pins

  // master byte with rate check, a colliding write and the peer's reply
  task automatic mt(input logic [1:0] m, input logic bs, input int hp, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    mode_sel <= m;
    base_sel <= bs;
    msb_sel <= ~msb_sel;
    sps_peer_inst.tx = ~d;
    wr(d);
    step();
    chk({busy, sel_n_o, transfer_done_flag}, 3'b100);
    while (sck_o !== 1'b1 && n < 100)
    begin
      step();
      n++;
    end
    n = 0;
    while (sck_o === 1'b1 && n < 100)
    begin
      step();
      n++;
    end
    chk(n, hp);
    wr(~d);
    wait_done();
    // interrupt pulse stands only in the cycle the done flag rises
    chk(irq, 1'b1);
    chk(write_collision_flag, 1'b1);
    // fastest rates outrun the input synchroniser, so data is judged at slow rates
    if (hp >= 4)
      chk({rdata, sps_peer_inst.rx}, {~d, d});
    clr();
    chk({write_collision_flag, transfer_done_flag}, 2'b00);
  endtask : mt

  task automatic off_clr;
    wr(8'h3C);
    wr(8'hC3);
    wait_done();
    // a collided write is cleared and written again
    clr();
    wr(8'hC3);
    step();
    chk({write_collision_flag, busy}, 2'b01);
    wait_done();
    cfg(1'b0, 2'b01, 1'b1);
    chk({write_collision_flag, transfer_done_flag}, 2'b00);
  endtask : off_clr

  // slave byte: clock without select is ignored, then a real frame
  task automatic st(input logic [7:0] d);
    @(posedge clk);
    base_sel <= ~base_sel;
    cfg(1'b1, 2'b11, 1'b1);
    chk({sck_oe, sdo_oe, sel_oe}, 3'b010);
    wr(d);
    sps_peer_inst.xfer(~d, 1'b0);
    repeat (8) step();
    chk(transfer_done_flag, 1'b0);
    sps_peer_inst.xfer(~d, 1'b1);
    repeat (8) step();
    chk({transfer_done_flag, rdata, sps_peer_inst.rx}, {1'b1, ~d, d});
    clr();
  endtask : st

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    pins();
    mt(2'b00, 1'b1, 1, 8'hA5);
    mt(2'b01, 1'b0, 4, 8'h96);
    mt(2'b10, 1'b1, 8, 8'h1E);
    off_clr();
    st(8'h69);
    print_verdict();
  end
endmodule : tb_sps_port
